//--- hw/iop_top.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "iop_defs.svh"

module iop_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port a pad
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    output logic [7:0] pa_pullup_en,
    output logic [7:0] pa_pulldown_en,
    // port b pad
    input wire logic [5:0] pb_in,
    output logic [5:0] pb_out,
    output logic [5:0] pb_oe,
    output logic [5:0] pb_pullup_en,
    output logic [5:0] pb_pulldown_en,
    // alternate sources
    input wire logic ir_carrier,
    input wire logic comparator_out,
    input wire logic pwm1_out,
    input wire logic buzzer1_out,
    input wire logic pwm2_out,
    input wire logic buzzer2_out,
    input wire logic instr_clk,
    // alternate sinks
    output logic ext_int0,
    output logic ext_int1,
    output logic timer0_ext_clk,
    output logic timer1_ext_clk,
    output logic timer2_ext_clk,
    output logic timer3_ext_clk,
    output logic ext_reset_n,
    output logic xtal_release,
    // interrupt
    output logic port_change_irq
);

    // ************************************************
    // registers
    // ************************************************
    logic [7:0] port_a_data_ff, port_a_direction_ff, port_a_pullup_ctrl_ff;
    logic [7:0] shared_pulldown_ctrl_ff, port_a_change_select_ff, power_ctrl_ff;
    logic [5:0] port_b_data_ff, port_b_direction_ff, port_b_pullup_ctrl_ff;
    logic [5:0] port_b_open_drain_ctrl_ff, port_b_change_select_ff;
    logic [7:0] ext_int_edge_ctrl_ff;
    logic [10:0] alt_ctrl_ff;
    logic [2:0] cfg_ff;
    logic port_change_flag_ff, port_change_int_enable_ff, global_int_enable_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;

    logic wr_acc, rd_setup, hit;
    iop_pkg::iop_word_t nxt_rdata;
    logic [7:0] chg_a;
    logic [5:0] chg_b, sel_b_eff;

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    function automatic logic known(input logic [11:0] a);
        known = (a <= `IOP_OFF_CFG) && (a[1:0] == 2'b00);
    endfunction : known

    // ************************************************
    // apb slave
    // ************************************************
    assign wr_acc = psel & penable & pready_ff & pwrite;
    assign rd_setup = psel & ~penable;
    assign hit = known(paddr);

    always_comb begin
        nxt_rdata = '0;
        if (reg_hit(paddr, `IOP_OFF_PA_DATA)) begin
            nxt_rdata[7:0] = pa_in;
        end else if (reg_hit(paddr, `IOP_OFF_PB_DATA)) begin
            nxt_rdata[5:0] = pb_in;
        end else if (reg_hit(paddr, `IOP_OFF_PA_DIR)) begin
            nxt_rdata[7:0] = port_a_direction_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PB_DIR)) begin
            nxt_rdata[5:0] = port_b_direction_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PA_PU)) begin
            nxt_rdata[7:0] = port_a_pullup_ctrl_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PD)) begin
            nxt_rdata[7:0] = shared_pulldown_ctrl_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PB_PU)) begin
            nxt_rdata[5:0] = port_b_pullup_ctrl_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PWR)) begin
            nxt_rdata[7:0] = power_ctrl_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PB_OD)) begin
            nxt_rdata[5:0] = port_b_open_drain_ctrl_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PA_CHG)) begin
            nxt_rdata[7:0] = port_a_change_select_ff;
        end else if (reg_hit(paddr, `IOP_OFF_PB_CHG)) begin
            nxt_rdata[5:0] = port_b_change_select_ff;
        end else if (reg_hit(paddr, `IOP_OFF_INT)) begin
            nxt_rdata[2:0] = {global_int_enable_ff, port_change_int_enable_ff,
                              port_change_flag_ff};
        end else if (reg_hit(paddr, `IOP_OFF_EDGE)) begin
            nxt_rdata[7:0] = ext_int_edge_ctrl_ff;
        end else if (reg_hit(paddr, `IOP_OFF_ALT)) begin
            nxt_rdata[10:0] = alt_ctrl_ff;
        end else if (reg_hit(paddr, `IOP_OFF_CFG)) begin
            nxt_rdata[2:0] = cfg_ff;
        end
    end

    // answer in the access phase, no wait states
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= rd_setup;
            pslverr_ff <= rd_setup & ~hit;
            if (rd_setup) begin
                prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_a_data_ff <= `IOP_RST_ZERO;
            port_b_data_ff <= 6'h00;
            port_a_direction_ff <= `IOP_RST_DIR_A;
            port_b_direction_ff <= `IOP_RST_DIR_B;
        end else if (wr_acc) begin
            if (reg_hit(paddr, `IOP_OFF_PA_DATA)) begin
                port_a_data_ff <= pwdata[7:0];
            end else if (reg_hit(paddr, `IOP_OFF_PB_DATA)) begin
                port_b_data_ff <= pwdata[5:0];
            end else if (reg_hit(paddr, `IOP_OFF_PA_DIR)) begin
                port_a_direction_ff <= pwdata[7:0];
            end else if (reg_hit(paddr, `IOP_OFF_PB_DIR)) begin
                port_b_direction_ff <= pwdata[5:0];
            end
        end
    end

    // pull, open-drain, select and alternate controls
    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_a_pullup_ctrl_ff <= `IOP_RST_ZERO;
            shared_pulldown_ctrl_ff <= `IOP_RST_ZERO;
            port_b_pullup_ctrl_ff <= 6'h00;
            power_ctrl_ff <= `IOP_RST_ZERO;
            port_b_open_drain_ctrl_ff <= 6'h00;
            port_a_change_select_ff <= `IOP_RST_ZERO;
            port_b_change_select_ff <= 6'h00;
            ext_int_edge_ctrl_ff <= `IOP_RST_ZERO;
            alt_ctrl_ff <= 11'h000;
            cfg_ff <= 3'h0;
            port_change_int_enable_ff <= 1'b0;
            global_int_enable_ff <= 1'b0;
        end else if (wr_acc) begin
            if (reg_hit(paddr, `IOP_OFF_PA_PU)) begin
                port_a_pullup_ctrl_ff <= pwdata[7:0];
            end else if (reg_hit(paddr, `IOP_OFF_PD)) begin
                shared_pulldown_ctrl_ff <= pwdata[7:0];
            end else if (reg_hit(paddr, `IOP_OFF_PB_PU)) begin
                port_b_pullup_ctrl_ff <= pwdata[5:0];
            end else if (reg_hit(paddr, `IOP_OFF_PWR)) begin
                power_ctrl_ff <= pwdata[7:0];
            end else if (reg_hit(paddr, `IOP_OFF_PB_OD)) begin
                port_b_open_drain_ctrl_ff <= pwdata[5:0];
            end else if (reg_hit(paddr, `IOP_OFF_PA_CHG)) begin
                port_a_change_select_ff <= pwdata[7:0];
            end else if (reg_hit(paddr, `IOP_OFF_PB_CHG)) begin
                port_b_change_select_ff <= pwdata[5:0];
            end else if (reg_hit(paddr, `IOP_OFF_INT)) begin
                port_change_int_enable_ff <= pwdata[`IOP_INT_PIE];
                global_int_enable_ff <= pwdata[`IOP_INT_GIE];
            end else if (reg_hit(paddr, `IOP_OFF_EDGE)) begin
                ext_int_edge_ctrl_ff <= pwdata[7:0];
            end else if (reg_hit(paddr, `IOP_OFF_ALT)) begin
                alt_ctrl_ff <= pwdata[10:0];
            end else if (reg_hit(paddr, `IOP_OFF_CFG)) begin
                cfg_ff <= pwdata[2:0];
            end
        end
    end

    // ************************************************
    // change detection
    // ************************************************
    // ext interrupt masks change detect on b1:0
    assign sel_b_eff = port_b_change_select_ff &
                       ~{4'h0, ext_int_edge_ctrl_ff[`IOP_EDGE_EI1],
                         ext_int_edge_ctrl_ff[`IOP_EDGE_EI0]};

    iop_chg_det #(.W(8)) u_chg_a (
        .core_clk(core_clk),
        .pin_in(pa_in),
        .select(port_a_change_select_ff),
        .change(chg_a)
    );

    iop_chg_det #(.W(6)) u_chg_b (
        .core_clk(core_clk),
        .pin_in(pb_in),
        .select(sel_b_eff),
        .change(chg_b)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_change_flag_ff <= 1'b0;
        end else if ((|chg_a) || (|chg_b)) begin
            port_change_flag_ff <= 1'b1;
        end else if (wr_acc && reg_hit(paddr, `IOP_OFF_INT) && !pwdata[`IOP_INT_FLAG]) begin
            port_change_flag_ff <= 1'b0;
        end
    end

    // ************************************************
    // pad muxing
    // ************************************************
    logic [7:0] a_alt_en, a_alt_val, a_od, nxt_pa_out, nxt_pa_oe;
    logic [5:0] b_alt_en, b_alt_val, nxt_pb_out, nxt_pb_oe;
    iop_pkg::iop_src_t pb3_src, pb2_src;
    logic xtal, clkout;

    assign xtal = cfg_ff[`IOP_CFG_XTAL];
    assign clkout = cfg_ff[`IOP_CFG_CLKOUT] & ~xtal;

    always_comb begin
        if (alt_ctrl_ff[`IOP_ALT_COMPARATOR_OUT_ENABLE]) begin
            pb3_src = iop_pkg::IOP_SRC_ALT1;
        end else if (alt_ctrl_ff[`IOP_ALT_PWM1]) begin
            pb3_src = iop_pkg::IOP_SRC_ALT2;
        end else if (alt_ctrl_ff[`IOP_ALT_BZ1]) begin
            pb3_src = iop_pkg::IOP_SRC_ALT3;
        end else begin
            pb3_src = iop_pkg::IOP_SRC_GPIO;
        end
    end

    always_comb begin
        if (alt_ctrl_ff[`IOP_ALT_PWM2]) begin
            pb2_src = iop_pkg::IOP_SRC_ALT1;
        end else if (alt_ctrl_ff[`IOP_ALT_BZ2]) begin
            pb2_src = iop_pkg::IOP_SRC_ALT2;
        end else begin
            pb2_src = iop_pkg::IOP_SRC_GPIO;
        end
    end

    always_comb begin
        b_alt_en = 6'h00;
        b_alt_val = 6'h00;
        case (pb3_src)
            iop_pkg::IOP_SRC_ALT1: b_alt_val[3] = comparator_out;
            iop_pkg::IOP_SRC_ALT2: b_alt_val[3] = pwm1_out;
            iop_pkg::IOP_SRC_ALT3: b_alt_val[3] = buzzer1_out;
            default: b_alt_val[3] = 1'b0;
        endcase
        b_alt_en[3] = (pb3_src != iop_pkg::IOP_SRC_GPIO);
        b_alt_val[2] = (pb2_src == iop_pkg::IOP_SRC_ALT1) ? pwm2_out : buzzer2_out;
        b_alt_en[2] = (pb2_src != iop_pkg::IOP_SRC_GPIO);
        b_alt_en[1] = alt_ctrl_ff[`IOP_ALT_IR];
        b_alt_val[1] = ir_carrier;
    end

    // a5 always open-drain; instruction clock on a7
    assign a_od = 8'h20;
    assign a_alt_en = {clkout, 7'h00};
    assign a_alt_val = {instr_clk, 7'h00};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pa
            iop_pad u_pad (
                .dout(port_a_data_ff[gi]),
                .dir_in(port_a_direction_ff[gi]),
                .open_drain(a_od[gi]),
                .alt_en(a_alt_en[gi]),
                .alt_val(a_alt_val[gi]),
                .pad_out(nxt_pa_out[gi]),
                .pad_oe(nxt_pa_oe[gi])
            );
        end
        for (gi = 0; gi < 6; gi++) begin : g_pb
            iop_pad u_pad (
                .dout(port_b_data_ff[gi]),
                .dir_in(port_b_direction_ff[gi]),
                .open_drain(port_b_open_drain_ctrl_ff[gi]),
                .alt_en(b_alt_en[gi]),
                .alt_val(b_alt_val[gi]),
                .pad_out(nxt_pb_out[gi]),
                .pad_oe(nxt_pb_oe[gi])
            );
        end
    endgenerate

    // ************************************************
    // pad and pull outputs
    // ************************************************
    logic [7:0] a_released, a_in_mode;
    logic [5:0] b_in_mode;
    assign a_released = {xtal | clkout, xtal, cfg_ff[`IOP_CFG_RSTPIN], 5'h00};
    assign a_in_mode = port_a_direction_ff & ~a_released & ~a_alt_en;
    assign b_in_mode = port_b_direction_ff & ~b_alt_en;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pa_out <= 8'h00;
            pa_oe <= 8'h00;
            pb_out <= 6'h00;
            pb_oe <= 6'h00;
        end else begin
            pa_out <= nxt_pa_out;
            pa_oe <= nxt_pa_oe & ~({xtal, xtal, cfg_ff[`IOP_CFG_RSTPIN], 5'h00});
            pb_out <= nxt_pb_out;
            pb_oe <= nxt_pb_oe;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pa_pullup_en <= 8'h00;
            pa_pulldown_en <= 8'h00;
            pb_pullup_en <= 6'h00;
            pb_pulldown_en <= 6'h00;
        end else begin
            pa_pullup_en <= a_in_mode & {port_a_pullup_ctrl_ff[7:6],
                                         power_ctrl_ff[`IOP_PWR_PA5_PU],
                                         port_a_pullup_ctrl_ff[4:0]};
            pa_pulldown_en <= a_in_mode & {2'b00, port_a_pullup_ctrl_ff[5], 1'b0,
                                           shared_pulldown_ctrl_ff[3:0]};
            pb_pullup_en <= b_in_mode & port_b_pullup_ctrl_ff;
            pb_pulldown_en <= b_in_mode & {2'b00, shared_pulldown_ctrl_ff[7:4]};
        end
    end

    // ************************************************
    // alternate inputs and interrupt
    // ************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ext_int0 <= 1'b0;
            ext_int1 <= 1'b0;
            timer0_ext_clk <= 1'b0;
            timer1_ext_clk <= 1'b0;
            timer2_ext_clk <= 1'b0;
            timer3_ext_clk <= 1'b0;
            ext_reset_n <= 1'b1;
            xtal_release <= 1'b0;
            port_change_irq <= 1'b0;
        end else begin
            ext_int0 <= ext_int_edge_ctrl_ff[`IOP_EDGE_EI0] & pb_in[0];
            ext_int1 <= ext_int_edge_ctrl_ff[`IOP_EDGE_EI1] & pb_in[1];
            timer0_ext_clk <= alt_ctrl_ff[`IOP_ALT_TIMER0_CLOCK_SELECT] & ~alt_ctrl_ff[`IOP_ALT_T0LCK] & pa_in[4];
            timer1_ext_clk <= alt_ctrl_ff[`IOP_ALT_TIMER1_CLOCK_SELECT] & pa_in[4];
            timer2_ext_clk <= alt_ctrl_ff[`IOP_ALT_TIMER2_CLOCK_SELECT] & pa_in[1];
            timer3_ext_clk <= alt_ctrl_ff[`IOP_ALT_TIMER3_CLOCK_SELECT] & pa_in[1];
            ext_reset_n <= ~(cfg_ff[`IOP_CFG_RSTPIN] & ~pa_in[5]);
            xtal_release <= xtal;
            port_change_irq <= port_change_flag_ff & port_change_int_enable_ff &
                               global_int_enable_ff;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_pa_data_write: assert property (
        wr_acc && paddr == `IOP_OFF_PA_DATA |=> port_a_data_ff == $past(pwdata[7:0]))
        else $error("port a data not stored");
    a_input_not_driven: assert property (
        pa_oe[0] |-> !$past(port_a_direction_ff[0]))
        else $error("input pin driven");
    a_pb_open_drain: assert property (
        !port_b_direction_ff[0] && port_b_open_drain_ctrl_ff[0] && port_b_data_ff[0]
        |=> !pb_oe[0])
        else $error("open-drain high driven");
    a_pa5_open_drain: assert property (
        pa_oe[5] |-> !pa_out[5])
        else $error("a5 drives high");
    a_change_sets_flag: assert property (
        (|chg_a) |=> port_change_flag_ff)
        else $error("change flag not set");
    a_irq_gated: assert property (
        port_change_irq |-> $past(port_change_flag_ff && port_change_int_enable_ff &&
                                  global_int_enable_ff))
        else $error("irq without enables");
    a_ext_int_wins: assert property (
        ext_int_edge_ctrl_ff[`IOP_EDGE_EI0] |-> !chg_b[0])
        else $error("b0 change with ext int");
    a_cmp_priority: assert property (
        alt_ctrl_ff[`IOP_ALT_COMPARATOR_OUT_ENABLE] && !port_b_open_drain_ctrl_ff[3]
        |=> pb_out[3] == $past(comparator_out) && pb_oe[3])
        else $error("b3 not comparator");
    a_reset_pin: assert property (
        cfg_ff[`IOP_CFG_RSTPIN] && !pa_in[5] |=> !ext_reset_n)
        else $error("reset pin ignored");

endmodule : iop_top

//--- pkg/iop_defs.svh
`ifndef IOP_DEFS_SVH
`define IOP_DEFS_SVH

// ************************************************
// register byte offsets
// ************************************************
`define IOP_OFF_PA_DATA 12'h000
`define IOP_OFF_PB_DATA 12'h004
`define IOP_OFF_PA_DIR 12'h008
`define IOP_OFF_PB_DIR 12'h00C
`define IOP_OFF_PA_PU 12'h010
`define IOP_OFF_PD 12'h014
`define IOP_OFF_PB_PU 12'h018
`define IOP_OFF_PWR 12'h01C
`define IOP_OFF_PB_OD 12'h020
`define IOP_OFF_PA_CHG 12'h024
`define IOP_OFF_PB_CHG 12'h028
`define IOP_OFF_INT 12'h02C
`define IOP_OFF_EDGE 12'h030
`define IOP_OFF_ALT 12'h034
`define IOP_OFF_CFG 12'h038

// ************************************************
// field positions
// ************************************************
`define IOP_PWR_PA5_PU 4
`define IOP_INT_FLAG 0
`define IOP_INT_PIE 1
`define IOP_INT_GIE 2
`define IOP_EDGE_EI0 4
`define IOP_EDGE_EI1 5
`define IOP_ALT_IR 0
`define IOP_ALT_TIMER0_CLOCK_SELECT 1
`define IOP_ALT_T0LCK 2
`define IOP_ALT_TIMER1_CLOCK_SELECT 3
`define IOP_ALT_TIMER2_CLOCK_SELECT 4
`define IOP_ALT_TIMER3_CLOCK_SELECT 5
`define IOP_ALT_COMPARATOR_OUT_ENABLE 6
`define IOP_ALT_PWM1 7
`define IOP_ALT_BZ1 8
`define IOP_ALT_PWM2 9
`define IOP_ALT_BZ2 10
`define IOP_CFG_RSTPIN 0
`define IOP_CFG_XTAL 1
`define IOP_CFG_CLKOUT 2

// ************************************************
// reset values
// ************************************************
`define IOP_RST_DIR_A 8'hFF
`define IOP_RST_DIR_B 6'h3F
`define IOP_RST_ZERO 8'h00

`endif

//--- pkg/iop_pkg.sv
package iop_pkg;

    // source steering a shared output pin
    typedef enum logic [1:0] {
        IOP_SRC_GPIO = 2'b00,
        IOP_SRC_ALT1 = 2'b01,
        IOP_SRC_ALT2 = 2'b10,
        IOP_SRC_ALT3 = 2'b11
    } iop_src_t;

    typedef logic [31:0] iop_word_t;

endpackage : iop_pkg

//--- hw/iop_pad.sv
`timescale 1ns/10ps

module iop_pad (
    // pin controls
    input wire logic dout,
    input wire logic dir_in,
    input wire logic open_drain,
    input wire logic alt_en,
    input wire logic alt_val,
    // pad drive
    output logic pad_out,
    output logic pad_oe
);

    always_comb begin
        if (alt_en) begin
            pad_out = open_drain ? 1'b0 : alt_val;
            pad_oe = open_drain ? ~alt_val : 1'b1;
        end else if (dir_in) begin
            pad_out = 1'b0;
            pad_oe = 1'b0;
        end else begin
            pad_out = open_drain ? 1'b0 : dout;
            pad_oe = open_drain ? ~dout : 1'b1;
        end
    end

endmodule : iop_pad

//--- hw/iop_chg_det.sv
`timescale 1ns/10ps

module iop_chg_det #(
    parameter int W = 8
) (
    // clock
    input wire logic core_clk,
    // pins
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] select,
    // result
    output logic [W-1:0] change
);

    logic [W-1:0] prev_ff;

    // previous level, free running
    always_ff @(posedge core_clk) begin
        prev_ff <= pin_in;
    end

    assign change = select & (pin_in ^ prev_ff);

endmodule : iop_chg_det

//--- sim/iop_pins.sv
`timescale 1ns/10ps

// ****
// board side of the pads
// ****
module iop_pins #(
    parameter int W = 8
) (
    // clock
    input wire logic core_clk,
    // device pad
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] pu_en,
    input wire logic [W-1:0] pd_en,
    // board drive
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin
);
    logic [W-1:0] last_ff;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pu_en[i] ? 1'b1 : pd_en[i] ? 1'b0 : ~last_ff[i];
        end
    end
    always_ff @(posedge core_clk) begin
        last_ff <= pin;
    end
endmodule : iop_pins

//--- sim/test_io_port_pin_control.sv
`timescale 1ns/10ps

module test_io_port_pin_control;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pullup_en, pa_pulldown_en, ext_a, en_a;
    logic [5:0] pb_in, pb_out, pb_oe, pb_pullup_en, pb_pulldown_en, ext_b, en_b;
    logic ir_carrier, comparator_out, pwm1_out, buzzer1_out, pwm2_out, buzzer2_out;
    logic instr_clk, ext_int0, ext_int1, timer0_ext_clk, timer1_ext_clk, timer2_ext_clk;
    logic timer3_ext_clk, ext_reset_n, xtal_release, port_change_irq;
    int n_errors = 0;
    int checks_done = 0;
    // address, write data, expected readback
    logic [75:0] rows [0:5] = '{{12'h00C, 32'hFF, 32'h3F}, {12'h018, 32'hFF, 32'h3F},
        {12'h020, 32'hFF, 32'h3F}, {12'h028, 32'hFF, 32'h3F},
        {12'h024, 32'hFF, 32'hFF}, {12'h03C, 32'hFF, 32'h00}};

    iop_top i_iop_top (.*);
    iop_pins #(.W(8)) i_iop_pins_a (.core_clk(core_clk), .pad_out(pa_out), .pad_oe(pa_oe),
        .pu_en(pa_pullup_en), .pd_en(pa_pulldown_en), .ext_val(ext_a), .ext_en(en_a),
        .pin(pa_in));
    iop_pins #(.W(6)) i_iop_pins_b (.core_clk(core_clk), .pad_out(pb_out), .pad_oe(pb_oe),
        .pu_en(pb_pullup_en), .pd_en(pb_pulldown_en), .ext_val(ext_b), .ext_en(en_b),
        .pin(pb_in));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ****
    // bus and compare tasks
    // ****
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    initial begin
        #80000;
        n_errors++;
        summarize();
    end

    // ****
    // main sequence
    // ****
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {ir_carrier, comparator_out, pwm1_out, buzzer1_out, pwm2_out, buzzer2_out} = 6'h00;
        {instr_clk, ext_a, ext_b, en_a, en_b} = {15'h0, 8'hFF, 6'h3F};
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        apb(0, 12'h008, 0);
        chk("pa_dir", 32'hFF, q);
        chk("pa_oe", 32'h0, pa_oe);
        for (int i = 0; i < 6; i++) begin
            apb(1, rows[i][75:64], rows[i][63:32]);
            apb(0, rows[i][75:64], 0);
            chk("readback", rows[i][31:0], q);
        end
        chk("pslverr", 32'h1, se);
        apb(1, 12'h010, 32'hFF);
        apb(1, 12'h014, 32'hFF);
        repeat (2) @(posedge core_clk);
        chk("pa_pu", 32'hDF, pa_pullup_en);
        chk("pa_pd", 32'h2F, pa_pulldown_en);
        chk("pb_pd", 32'h0F, pb_pulldown_en);
        chk("pb_pu", 32'h3F, pb_pullup_en);
        apb(1, 12'h01C, 32'h10);
        repeat (2) @(posedge core_clk);
        chk("pa_pu", 32'hFF, pa_pullup_en);
        apb(1, 12'h008, 32'h00);
        apb(1, 12'h000, 32'hA5);
        apb(1, 12'h020, 32'h01);
        apb(1, 12'h00C, 32'h00);
        apb(1, 12'h004, 32'h03);
        repeat (2) @(posedge core_clk);
        chk("pa_oe", 32'hDF, pa_oe);
        chk("pa_out", 32'h85, pa_out & pa_oe);
        chk("pb_oe", 32'h3E, pb_oe);
        chk("pb_out", 32'h02, pb_out & pb_oe);
        apb(1, 12'h008, 32'hFF);
        apb(1, 12'h024, 32'h01);
        apb(1, 12'h028, 32'h01);
        apb(1, 12'h02C, 32'h00);
        ext_a <= 8'h01;
        repeat (3) @(posedge core_clk);
        chk("irq", 32'h0, port_change_irq);
        apb(1, 12'h02C, 32'h07);
        repeat (3) @(posedge core_clk);
        chk("irq", 32'h1, port_change_irq);
        apb(1, 12'h02C, 32'h06);
        apb(1, 12'h030, 32'h30);
        ext_b <= 6'h01;
        repeat (3) @(posedge core_clk);
        chk("ext_int0", 32'h1, ext_int0);
        chk("ext_int1", 32'h1, ext_int1);
        apb(0, 12'h02C, 0);
        chk("flag", 32'h0, q[0]);
        {ir_carrier, comparator_out, pwm2_out} <= 3'b111;
        apb(1, 12'h034, 32'h2FB);
        apb(1, 12'h038, 32'h03);
        ext_a <= 8'h13;
        repeat (3) @(posedge core_clk);
        chk("pb1", 32'h1, pb_out[1]);
        chk("pb3", 32'h1, pb_out[3]);
        chk("pb2", 32'h1, pb_out[2]);
        chk("t0clk", 32'h1, timer0_ext_clk);
        chk("t1clk", 32'h1, timer1_ext_clk);
        chk("t2clk", 32'h1, timer2_ext_clk);
        chk("t3clk", 32'h1, timer3_ext_clk);
        chk("rst_n", 32'h0, ext_reset_n);
        chk("xtal", 32'h1, xtal_release);
        {pwm1_out, instr_clk} <= 2'b11;
        apb(1, 12'h034, 32'h780);
        apb(1, 12'h038, 32'h04);
        repeat (3) @(posedge core_clk);
        chk("pb3", 32'h1, pb_out[3]);
        chk("pb2", 32'h1, pb_out[2]);
        chk("pa7", 32'h1, pa_out[7] & pa_oe[7]);
        chk("rst_n", 32'h1, ext_reset_n);
        chk("xtal", 32'h0, xtal_release);
        {pwm1_out, pwm2_out, buzzer1_out, buzzer2_out} <= 4'b0011;
        apb(1, 12'h034, 32'h500);
        repeat (3) @(posedge core_clk);
        chk("pb3", 32'h1, pb_out[3]);
        chk("pb2", 32'h1, pb_out[2]);
        // mid-run reset back to defaults
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        apb(0, 12'h034, 0);
        chk("alt", 32'h0, q);
        chk("pa_oe", 32'h0, pa_oe);
        chk("pb_oe", 32'h0, pb_oe);
        summarize();
    end
endmodule : test_io_port_pin_control
